/* sfc_pkg.sv */
package sfc_pkg;

    // ****************************************************************
    // Op-codes
    // ****************************************************************
    localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATUS       = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS      = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ        = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE       = 8'h02;
    localparam logic [7:0] OP_FAST_READ_ARRAY   = 8'h0B;
    localparam logic [7:0] OP_DEEP_POWER_DOWN   = 8'hBA;
    localparam logic [7:0] OP_ID_READ           = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID_READ    = 8'h4C;
    localparam logic [7:0] OP_SERIAL_NUM_WRITE  = 8'hC2;
    localparam logic [7:0] OP_SERIAL_NUM_READ   = 8'hC3;
    localparam logic [7:0] OP_SPECIAL_WRITE     = 8'h42;
    localparam logic [7:0] OP_SPECIAL_READ      = 8'h4B;
    localparam logic [7:0] OP_SPECIAL_FAST_READ = 8'h49;

    // ****************************************************************
    // Frame and status layout
    // ****************************************************************
    localparam int         OP_BITS          = 8;
    localparam logic [2:0] LAST_BIT_IDX     = 3'h7;
    localparam int         STAT_PROTECT_BIT = 7;
    localparam int         STAT_SPARE_HI    = 6;
    localparam int         STAT_SPARE_LO    = 4;
    localparam int         STAT_BP_HI_BIT   = 3;
    localparam int         STAT_BP_LO_BIT   = 2;
    localparam int         STAT_NV_LO       = 2;
    localparam int         STAT_WEL_BIT     = 1;
    localparam int         STAT_ZERO_BIT    = 0;
    localparam logic [5:0] STAT_NV_RESET    = 6'h00;
    localparam int         SYNC_STAGES      = 2;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b001,
        PH_DATA   = 3'b010,
        PH_DONE   = 3'b100
    } sfc_phase_type;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] data;
    } sfc_xfer_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] op;
        logic       write_ok;
    } sfc_cmd_type;

endpackage : sfc_pkg

/* sfc_spi_cmd_status.sv */
`timescale 1ns/10ps
// What this block does
// - Works in SPI mode 0 and mode 3; master uses only those two.
// - Acts only as slave; never drives serial clock or chip select.
// - Chip select high: standby, output released, other inputs ignored.
// - Serial input sampled on rising edge, output changed on falling edge.
// - Every command starts with exactly eight op-code bits after select.
// - Op-code 06 sets the write latch, 04 clears it.
// - Array read 03, array write 02, fast array read 0B decoded.
// - Special sector write 42, read 4B, fast read 49 decoded.
// - Op-code BA enters deep power-down.
// - Status read 05, status write 01; fields written and read back.
// - Exactly fifteen commands accepted, including 9F, 4C, C2, C3.
// - Chip select rising mid op-code discards it; nothing is performed.
// - Bit 7 protect-enable is stored, read, written; gates status writes with pin.
// - Bits 6 to 4 unused but stored, written and read back.
// - Bits 3 and 2 block-protect stored, written and read back.
// - Bit 1 shows the write latch; status write never alters it.
// - Latch cleared at power-on, on clear command, on leaving power-down.
// - Latch stays set after status, array, serial-number, special writes.
// - Bit 0 always reads zero and no command changes it.
// - Writes refused while latch is clear; master sets latch first.
// - Status write takes next eight bits, ignores latch and zero positions.
module sfc_spi_cmd_status
    import sfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_si,
    input  wire logic        write_protect_n,
    output logic             spi_so,
    output logic             spi_so_oe,
    output logic [7:0]       status_out,
    output logic             power_down,
    output logic             cmd_valid,
    output logic [7:0]       cmd_op,
    output logic             cmd_write_ok
);

    // ****************************************************************
    // Decoders
    // ****************************************************************
    function automatic logic sfc_is_known(input logic [7:0] op);
        unique case (op)
            OP_SET_WRITE_LATCH, OP_CLEAR_WRITE_LATCH, OP_READ_STATUS,
            OP_WRITE_STATUS, OP_ARRAY_READ, OP_ARRAY_WRITE,
            OP_FAST_READ_ARRAY, OP_DEEP_POWER_DOWN, OP_ID_READ,
            OP_UNIQUE_ID_READ, OP_SERIAL_NUM_WRITE, OP_SERIAL_NUM_READ,
            OP_SPECIAL_WRITE, OP_SPECIAL_READ, OP_SPECIAL_FAST_READ: begin
                sfc_is_known = 1'b1;
            end
            default: begin
                sfc_is_known = 1'b0;
            end
        endcase
    endfunction : sfc_is_known

    function automatic logic sfc_is_write(input logic [7:0] op);
        sfc_is_write = (op == OP_WRITE_STATUS) || (op == OP_ARRAY_WRITE) ||
                       (op == OP_SERIAL_NUM_WRITE) || (op == OP_SPECIAL_WRITE);
    endfunction : sfc_is_write

    // ****************************************************************
    // Link domain: shifter on the serial clock
    // ****************************************************************
    // Only rising edges sample, so idle clock level (mode 0 or 3) is irrelevant
    sfc_phase_type phase_r;
    logic [2:0]    bitcnt_r;
    logic [7:0]    shift_r;
    logic          op_valid_r;
    logic          dat_valid_r;
    sfc_xfer_type  xfer_r;
    logic [7:0]    stat_s1_r;
    logic [7:0]    stat_s2_r;
    logic          so_r;
    logic          so_oe_r;

    wire  [7:0] shift_nxt = {shift_r[6:0], spi_si};
    wire        byte_end  = (bitcnt_r == LAST_BIT_IDX);
    wire        op_end    = (phase_r == PH_OPCODE) && byte_end;
    wire        wrs_end   = (phase_r == PH_DATA) && byte_end &&
                            (xfer_r.op == OP_WRITE_STATUS);
    wire        rds_phase = (phase_r == PH_DATA) && (xfer_r.op == OP_READ_STATUS);
    wire  [2:0] out_idx   = LAST_BIT_IDX - bitcnt_r;

    // Chip select high clears the frame: partial op-codes vanish
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            phase_r     <= PH_OPCODE;
            bitcnt_r    <= 3'h0;
            shift_r     <= 8'h00;
            op_valid_r  <= 1'b0;
            dat_valid_r <= 1'b0;
        end else begin
            bitcnt_r <= bitcnt_r + 3'h1;
            shift_r  <= shift_nxt;
            unique case (phase_r)
                PH_OPCODE: begin
                    if (op_end) begin
                        phase_r    <= PH_DATA;
                        op_valid_r <= 1'b1;
                    end
                end
                PH_DATA: begin
                    if (wrs_end) begin
                        phase_r     <= PH_DONE;
                        dat_valid_r <= 1'b1;
                    end
                end
                PH_DONE: begin
                    phase_r <= PH_DONE;
                end
            endcase
        end
    end

    // Captured words outlive chip select so the other side reads them safely
    always_ff @(posedge spi_sck) begin
        if (!spi_cs_n && op_end) begin
            xfer_r.op <= shift_nxt;
        end
        if (!spi_cs_n && wrs_end) begin
            xfer_r.data <= shift_nxt;
        end
    end

    // Status word is quasi-static; it settles during the op-code bits
    always_ff @(posedge spi_sck) begin
        stat_s1_r <= status_out;
        stat_s2_r <= stat_s1_r;
    end

    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_r    <= rds_phase ? stat_s2_r[out_idx] : 1'b0;
            so_oe_r <= rds_phase;
        end
    end

    assign spi_so    = so_r;
    assign spi_so_oe = so_oe_r;

    // ****************************************************************
    // System domain: synchronisers
    // ****************************************************************
    logic [SYNC_STAGES-1:0] ov_sync_r;
    logic [SYNC_STAGES-1:0] dv_sync_r;
    logic [SYNC_STAGES-1:0] cs_sync_r;
    logic [SYNC_STAGES-1:0] wp_sync_r;
    logic                   ov_last_r;
    logic                   dv_last_r;
    logic                   cs_last_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ov_sync_r <= '0;
            dv_sync_r <= '0;
            cs_sync_r <= '1;
            wp_sync_r <= '1;
            ov_last_r <= 1'b0;
            dv_last_r <= 1'b0;
            cs_last_r <= 1'b1;
        end else if (ce) begin
            ov_sync_r <= {ov_sync_r[0], op_valid_r};
            dv_sync_r <= {dv_sync_r[0], dat_valid_r};
            cs_sync_r <= {cs_sync_r[0], spi_cs_n};
            wp_sync_r <= {wp_sync_r[0], write_protect_n};
            ov_last_r <= ov_sync_r[1];
            dv_last_r <= dv_sync_r[1];
            cs_last_r <= cs_sync_r[1];
        end
    end

    // ****************************************************************
    // System domain: status register and command effects
    // ****************************************************************
    logic [5:0] nv_r;
    logic       wel_r;
    logic       dpd_r;
    logic [7:0] status_r;
    logic       cmd_valid_r;
    logic [7:0] cmd_op_r;
    logic       cmd_write_ok_r;

    wire op_evt   = ce && ov_sync_r[1] && !ov_last_r && !dpd_r;
    wire dat_evt  = ce && dv_sync_r[1] && !dv_last_r && !dpd_r;
    wire wake_evt = ce && dpd_r && !cs_sync_r[1] && cs_last_r;
    wire op_set   = op_evt && (xfer_r.op == OP_SET_WRITE_LATCH);
    wire op_clr   = op_evt && (xfer_r.op == OP_CLEAR_WRITE_LATCH);
    wire op_dpd   = op_evt && (xfer_r.op == OP_DEEP_POWER_DOWN);
    // Protect-enable with the pin held low locks the status word
    wire stat_locked = nv_r[STAT_PROTECT_BIT-STAT_NV_LO] && !wp_sync_r[1];
    wire stat_wr  = dat_evt && (xfer_r.op == OP_WRITE_STATUS) &&
                    wel_r && !stat_locked;
    wire [5:0] nv_nxt  = stat_wr ? xfer_r.data[7:STAT_NV_LO] : nv_r;
    wire       wel_nxt = (op_clr || wake_evt) ? 1'b0 :
                         op_set ? 1'b1 : wel_r;
    wire [7:0] stat_nxt = {nv_nxt, wel_nxt, 1'b0};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            nv_r  <= STAT_NV_RESET;
            wel_r <= 1'b0;
            dpd_r <= 1'b0;
        end else if (ce) begin
            nv_r  <= nv_nxt;
            wel_r <= wel_nxt;
            dpd_r <= wake_evt ? 1'b0 : (op_dpd ? 1'b1 : dpd_r);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_r       <= 8'h00;
            cmd_valid_r    <= 1'b0;
            cmd_op_r       <= 8'h00;
            cmd_write_ok_r <= 1'b0;
        end else if (ce) begin
            status_r       <= stat_nxt;
            cmd_valid_r    <= op_evt && sfc_is_known(xfer_r.op);
            cmd_op_r       <= op_evt ? xfer_r.op : cmd_op_r;
            cmd_write_ok_r <= op_evt ? (sfc_is_write(xfer_r.op) && wel_r) : cmd_write_ok_r;
        end
    end

    assign status_out   = status_r;
    assign power_down   = dpd_r;
    assign cmd_valid    = cmd_valid_r;
    assign cmd_op       = cmd_op_r;
    assign cmd_write_ok = cmd_write_ok_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    zero_bit_a: assert property (status_r[STAT_ZERO_BIT] == 1'b0)
        else $error("status bit 0 not zero");
    latch_set_a: assert property (op_set |-> ##2 status_r[STAT_WEL_BIT])
        else $error("set latch command did not show in status");
    latch_clear_a: assert property (op_clr |=> !wel_r ##1 !status_r[STAT_WEL_BIT])
        else $error("clear latch command did not clear latch");
    wake_clear_a: assert property (wake_evt |=> !wel_r && !dpd_r)
        else $error("leaving power-down left latch or mode set");
    write_refused_a: assert property (dat_evt && !wel_r |=> $stable(nv_r))
        else $error("status written with latch clear");
    write_taken_a: assert property (stat_wr |=> nv_r == $past(xfer_r.data[STAT_PROTECT_BIT:STAT_NV_LO]) &&
                                    wel_r == $past(wel_r))
        else $error("status write value wrong or latch altered");
    protect_lock_a: assert property (dat_evt && stat_locked |=> $stable(nv_r))
        else $error("locked status was written");
    dpd_enter_a: assert property (op_dpd |=> dpd_r [*2])
        else $error("power-down not entered");
    cmd_pulse_a: assert property (cmd_valid_r |-> sfc_is_known(cmd_op_r) ##1 !cmd_valid_r)
        else $error("command strobe not a single known pulse");
    opcode_whole_a: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
                                     (phase_r == PH_OPCODE) |-> !op_valid_r)
        else $error("op-code accepted before eight bits");
    out_release_a: assert property (@(negedge spi_sck) disable iff (spi_cs_n)
                                    so_oe_r |-> (xfer_r.op == OP_READ_STATUS))
        else $error("output driven outside status read");

    set_latch_c: cover property (op_set ##[1:300] stat_wr);
    dpd_wake_c: cover property (op_dpd ##[1:200] wake_evt);
    locked_write_c: cover property (dat_evt && stat_locked);

endmodule : sfc_spi_cmd_status

/* sfc_spi_cmd_status_tb.sv */
`timescale 1ns/10ps
module sfc_spi_cmd_status_tb
    import sfc_pkg::*;
;
    logic       clk, resetn, ce, write_protect_n, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
    logic       power_down, cmd_valid, cmd_write_ok;
    logic [7:0] status_out, cmd_op, rd, op;
    int         bad_count, n_compared, valid_cnt, oe_cnt, c0;
    localparam logic [7:0] OPS [15] = '{OP_CLEAR_WRITE_LATCH, OP_SET_WRITE_LATCH, OP_READ_STATUS,
        OP_WRITE_STATUS, OP_ARRAY_READ, OP_ARRAY_WRITE, OP_FAST_READ_ARRAY, OP_ID_READ,
        OP_UNIQUE_ID_READ, OP_SERIAL_NUM_WRITE, OP_SERIAL_NUM_READ, OP_SPECIAL_WRITE,
        OP_SPECIAL_READ, OP_SPECIAL_FAST_READ, OP_DEEP_POWER_DOWN};

    sfc_spi_cmd_status DUT (.clk(clk), .resetn(resetn), .ce(ce), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .write_protect_n(write_protect_n), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .status_out(status_out), .power_down(power_down),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_write_ok(cmd_write_ok));
    sfc_spi_master_model m (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Sampled half a period after launch so the strobe has settled
    always @(negedge clk) if (cmd_valid === 1'b1) valid_cnt++;
    always @(negedge clk) if (spi_so_oe === 1'b1) oe_cnt++;

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    // Frame then let the clock-domain crossing settle
    task automatic xfer(input logic mode3, input logic [7:0] o, input logic h, input logic [7:0] d);
        m.frame(mode3, o, h, d, rd);
        repeat (4) @(negedge clk);
    endtask : xfer

    task automatic print_verdict();
        $display("bad_count %0d n_compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset();
        cmp8("status", 8'h00, status_out);
        cmp8("power_down", 8'h00, {7'h00, power_down});
        cmp8("so_oe", 8'h00, {7'h00, spi_so_oe});
    endtask : test_reset

    task automatic test_write_refused();
        xfer(1'b0, OP_WRITE_STATUS, 1'b1, 8'hFF);
        cmp8("status", 8'h00, status_out);
    endtask : test_write_refused

    task automatic test_write_read();
        xfer(1'b1, OP_SET_WRITE_LATCH, 1'b0, 8'h00);
        cmp8("status", 8'h02, status_out);
        xfer(1'b1, OP_WRITE_STATUS, 1'b1, 8'hFD);
        cmp8("status", 8'hFE, status_out);
        c0 = oe_cnt;
        xfer(1'b0, OP_READ_STATUS, 1'b1, 8'h00);
        cmp8("read", 8'hFE, rd);
        cmp8("so_oe_seen", 8'h01, {7'h00, (oe_cnt != c0)});
        cmp8("so_oe", 8'h00, {7'h00, spi_so_oe});
    endtask : test_write_read

    task automatic test_protect();
        write_protect_n = 1'b0;
        xfer(1'b0, OP_WRITE_STATUS, 1'b1, 8'h00);
        cmp8("status", 8'hFE, status_out);
        write_protect_n = 1'b1;
        xfer(1'b1, OP_WRITE_STATUS, 1'b1, 8'h03);
        cmp8("status", 8'h02, status_out);
        xfer(1'b1, OP_READ_STATUS, 1'b1, 8'hFF);
        cmp8("read", 8'h02, rd);
    endtask : test_protect

    task automatic test_clear_abort();
        xfer(1'b0, OP_CLEAR_WRITE_LATCH, 1'b0, 8'h00);
        cmp8("status", 8'h00, status_out);
        c0 = valid_cnt;
        m.abort(1'b1, 3'b000);
        repeat (4) @(negedge clk);
        cmp8("valid", 8'h00, 8'(valid_cnt - c0));
        cmp8("op", OP_CLEAR_WRITE_LATCH, cmd_op);
    endtask : test_clear_abort

    task automatic test_table();
        for (int i = 0; i < 15; i++) begin
            op = OPS[i];
            c0 = valid_cnt;
            xfer(i[0], op, 1'b0, 8'h00);
            cmp8("op", op, cmd_op);
            cmp8("valid", 8'h01, 8'(valid_cnt - c0));
            if (i > 0) cmp8("write_ok", {7'h00, (op inside {OP_WRITE_STATUS, OP_ARRAY_WRITE, OP_SERIAL_NUM_WRITE,
                OP_SPECIAL_WRITE})}, {7'h00, cmd_write_ok});
        end
        cmp8("power_down", 8'h01, {7'h00, power_down});
        cmp8("status", 8'h02, status_out);
        xfer(1'b0, OP_READ_STATUS, 1'b0, 8'h00);
        cmp8("power_down", 8'h00, {7'h00, power_down});
        cmp8("status", 8'h00, status_out);
    endtask : test_table

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        write_protect_n = 1'b1;
        bad_count = 0;
        n_compared = 0;
        valid_cnt = 0;
        oe_cnt = 0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        test_write_refused();
        test_write_read();
        test_protect();
        test_clear_abort();
        test_table();
        print_verdict();
    end

    // Whole run needs about 55 us; roughly nine times that means a hang
    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end
endmodule : sfc_spi_cmd_status_tb

/* sfc_spi_master_model.sv */
`timescale 1ns/10ps
module sfc_spi_master_model
    import sfc_pkg::*;
(
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    // ****************************************************************
    // Idle bus: deselected, clock parked
    // ****************************************************************
    // Select rises one step late so the shifter's async reset surely sees the edge
    initial begin
        spi_sck  = 1'b0;
        spi_si   = 1'b0;
        #1;
        spi_cs_n = 1'b1;
    end

    // ****************************************************************
    // One bit: data set on the leading edge side, sampled on the rise
    // ****************************************************************
    task automatic shift_bit(input logic mode3, input logic b, output logic rb);
        if (mode3) spi_sck = 1'b0;
        spi_si = b;
        #80;
        spi_sck = 1'b1;
        rb = spi_so;
        #80;
        if (!mode3) spi_sck = 1'b0;
    endtask : shift_bit

    // Odd start offset keeps the link edges off the system clock grid
    task automatic open_frame(input logic mode3);
        spi_sck = mode3;
        #43;
        spi_cs_n = 1'b0;
        #80;
    endtask : open_frame

    // Released line shows the inverse so a stale value cannot pass
    task automatic close_frame();
        #160;
        spi_cs_n = 1'b1;
        spi_si   = ~spi_si;
        #240;
    endtask : close_frame

    task automatic frame(input logic mode3, input logic [7:0] op, input logic has_data,
                         input logic [7:0] dat, output logic [7:0] rd);
        logic rb;
        rd = 8'h00;
        open_frame(mode3);
        for (int i = 7; i >= 0; i--) shift_bit(mode3, op[i], rb);
        if (has_data) for (int i = 7; i >= 0; i--) shift_bit(mode3, dat[i], rd[i]);
        close_frame();
    endtask : frame

    task automatic abort(input logic mode3, input logic [2:0] part);
        logic rb;
        open_frame(mode3);
        for (int i = 2; i >= 0; i--) shift_bit(mode3, part[i], rb);
        close_frame();
    endtask : abort
endmodule : sfc_spi_master_model
